/* File: core/etu_delay_timer.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Counts half-bit ticks after a start pulse, then pulses done
// ****************************************
module etu_delay_timer (
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    input  wire logic       i_start,
    input  wire logic       i_tick,
    input  wire logic [2:0] i_count,
    output var  logic       o_done
);

    logic [2:0] remain;
    logic       busy;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            remain <= 3'h0;
            busy   <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                remain <= i_count;
                busy   <= 1'b1;
            end else if (busy && i_tick) begin
                remain <= remain - 3'h1;
                if (remain == 3'h1) begin
                    busy   <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule : etu_delay_timer
`default_nettype wire

/* File: core/read_clear_flag.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// One status flag cleared by writing 0 after reading it as 1
// ****************************************
module read_clear_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic i_mclk,
    input  wire logic i_srst,
    input  wire logic i_set,
    input  wire logic i_read_one,
    input  wire logic i_write_done,
    input  wire logic i_write_zero,
    input  wire logic i_hw_clear,
    output var  logic o_flag
);

    logic armed;
    wire  sw_clear = i_write_zero && armed;

    // Set beats any clear landing in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_flag <= RESET_VAL;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (sw_clear || i_hw_clear) begin
            o_flag <= 1'b0;
        end
    end

    // A write consumes the arming whatever it carried
    always_ff @(posedge i_mclk) begin
        if (i_srst || i_write_done || !o_flag) begin
            armed <= 1'b0;
        end else if (i_read_one) begin
            armed <= 1'b1;
        end
    end

endmodule : read_clear_flag
`default_nettype wire

/* File: core/scstat_pkg.sv */
package scstat_pkg;

    // ****************************************
    // Register map (byte addresses, one word each)
    // ****************************************
    localparam logic [3:0] ADDR_STATUS     = 4'h0;
    localparam logic [3:0] ADDR_CONTROL    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'hC;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_PARITY_FAULT  = 3;
    localparam int BIT_TRANSMIT_DONE = 2;
    localparam int BIT_MULTIPROC_RX  = 1;
    localparam int BIT_MULTIPROC_TX  = 0;
    localparam int IRQ_PARITY        = 0;
    localparam int IRQ_DONE          = 1;
    localparam int CONTROL_WIDTH     = 5;
    localparam int IRQ_WIDTH         = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic clocked_sync;
        logic block_mode;
        logic guard_shorten;
        logic rx_enable;
        logic tx_enable;
    } ctrl_t;

    typedef struct packed {
        logic parity_fault;
        logic transmit_done;
        logic multiproc_rx;
        logic multiproc_tx;
    } status_t;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic  PARITY_FAULT_RESET  = 1'b0;
    localparam logic  TRANSMIT_DONE_RESET = 1'b1;
    localparam logic  MULTIPROC_RX_VALUE  = 1'b0;
    localparam logic  MULTIPROC_TX_RESET  = 1'b0;
    localparam ctrl_t CONTROL_RESET       = '{default: 1'b0};
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

    // ****************************************
    // Transmit-done delays, in bit times; counted in half-bit ticks
    // ****************************************
    localparam real DONE_DELAY_NORMAL_ETU = 2.5;
    localparam real DONE_DELAY_BLOCK_ETU  = 1.5;
    localparam real DONE_DELAY_GUARD_ETU  = 1.0;
    localparam int  HALF_TICKS_PER_ETU    = 2;
    localparam logic [2:0] HALF_TICKS_NORMAL =
        3'(int'(DONE_DELAY_NORMAL_ETU * real'(HALF_TICKS_PER_ETU)));
    localparam logic [2:0] HALF_TICKS_BLOCK =
        3'(int'(DONE_DELAY_BLOCK_ETU * real'(HALF_TICKS_PER_ETU)));
    localparam logic [2:0] HALF_TICKS_GUARD =
        3'(int'(DONE_DELAY_GUARD_ETU * real'(HALF_TICKS_PER_ETU)));

endpackage : scstat_pkg

/* File: core/smart_card_status_flags.sv */
`timescale 1ns/1ns
`default_nettype none

module smart_card_status_flags
    import scstat_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output var  logic [31:0] o_readdata,
    output var  logic        o_waitrequest,
    input  wire logic        i_rx_char_done,
    input  wire logic        i_rx_parity_bad,
    input  wire logic        i_tx_char_end,
    input  wire logic        i_half_etu_tick,
    input  wire logic        i_error_signal_flag,
    input  wire logic        i_transmit_empty_flag,
    input  wire logic        i_tx_hold_write,
    output var  logic        o_holding_load,
    output var  logic        o_receive_full_set,
    output var  logic        o_rx_halt,
    output var  logic        o_tx_halt,
    output var  logic        o_tx_enable_bit,
    output var  logic        o_rx_enable_bit,
    output var  logic        o_guard_shorten_mode,
    output var  logic        o_block_transfer_mode,
    output var  logic        o_transmit_done_flag,
    output var  logic        o_irq
);

    // ****************************************
    // Bus access decode
    // ****************************************
    ctrl_t                ctrl;
    status_t              status;
    logic                 multiproc_tx;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic                 parity_fault;
    logic                 transmit_done;
    logic                 prev_parity;
    logic                 prev_done;
    logic                 timer_done;

    // The access completes at the edge where waitrequest is seen low
    wire  bus_req    = i_read || i_write;
    wire  access_end = bus_req && !o_waitrequest;
    wire  wr_done    = access_end && i_write && i_byteenable[0];
    wire  rd_done    = access_end && i_read;
    wire  hit_status = i_address == ADDR_STATUS;
    wire  hit_ctrl   = i_address == ADDR_CONTROL;
    wire  hit_irqs   = i_address == ADDR_IRQ_STATUS;
    wire  hit_mask   = i_address == ADDR_IRQ_MASK;
    wire  wr_status  = wr_done && hit_status;
    wire  rd_status  = rd_done && hit_status;

    // ****************************************
    // Read mux
    // ****************************************
    assign status = '{parity_fault:  parity_fault,
                      transmit_done: transmit_done,
                      multiproc_rx:  MULTIPROC_RX_VALUE,
                      multiproc_tx:  multiproc_tx};

    wire [31:0] read_mux =
        hit_status ? {28'h0000000, status} :
        hit_ctrl   ? {27'h0000000, ctrl} :
        hit_irqs   ? {30'h00000000, irq_status} :
        hit_mask   ? {30'h00000000, irq_mask} :
                     32'h00000000;

    // One wait cycle: data is latched while waitrequest is high
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h00000000;
        end else begin
            o_waitrequest <= !(bus_req && o_waitrequest);
            if (bus_req && o_waitrequest && i_read) begin
                o_readdata <= read_mux;
            end
        end
    end

    // ****************************************
    // Software-writable registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl         <= CONTROL_RESET;
            irq_mask     <= IRQ_MASK_RESET;
            multiproc_tx <= MULTIPROC_TX_RESET;
        end else begin
            // Dropping rx enable touches nothing else here
            if (wr_done && hit_ctrl) begin
                ctrl <= ctrl_t'(i_writedata[CONTROL_WIDTH-1:0]);
            end
            if (wr_done && hit_mask) begin
                irq_mask <= i_writedata[IRQ_WIDTH-1:0];
            end
            // Stored as written; software keeps it at 0 here
            if (wr_status) begin
                multiproc_tx <= i_writedata[BIT_MULTIPROC_TX];
            end
        end
    end

    // ****************************************
    // Parity fault flag
    // ****************************************
    // Characters are ignored while the flag holds reception off
    wire rx_accept  = i_rx_char_done && !parity_fault;
    wire parity_set = rx_accept && i_rx_parity_bad;

    read_clear_flag #(
        .RESET_VAL (PARITY_FAULT_RESET)
    ) u_parity_flag (
        .i_mclk       (i_mclk),
        .i_srst       (i_srst),
        .i_set        (parity_set),
        .i_read_one   (rd_status && o_readdata[BIT_PARITY_FAULT]),
        .i_write_done (wr_status),
        .i_write_zero (wr_status && !i_writedata[BIT_PARITY_FAULT]),
        .i_hw_clear   (1'b0),
        .o_flag       (parity_fault)
    );

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_holding_load     <= 1'b0;
            o_receive_full_set <= 1'b0;
            o_rx_halt          <= 1'b0;
            o_tx_halt          <= 1'b0;
        end else begin
            o_holding_load     <= rx_accept;
            o_receive_full_set <= rx_accept && !i_rx_parity_bad;
            o_rx_halt          <= parity_fault || parity_set;
            o_tx_halt          <= (parity_fault || parity_set)
                                  && ctrl.clocked_sync;
        end
    end

    // ****************************************
    // Transmit done flag
    // ****************************************
    // Delay in half-bit ticks so 2.5 and 1.5 bit times are exact
    wire [2:0] delay_count = ctrl.guard_shorten ? HALF_TICKS_GUARD :
                             ctrl.block_mode    ? HALF_TICKS_BLOCK :
                                                  HALF_TICKS_NORMAL;

    etu_delay_timer u_done_timer (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_start (i_tx_char_end),
        .i_tick  (i_half_etu_tick),
        .i_count (delay_count),
        .o_done  (timer_done)
    );

    // The error signal flag is sampled from the low error level upstream
    wire done_idle  = !ctrl.tx_enable && !i_error_signal_flag;
    wire done_timed = timer_done && !i_error_signal_flag
                      && i_transmit_empty_flag;

    read_clear_flag #(
        .RESET_VAL (TRANSMIT_DONE_RESET)
    ) u_done_flag (
        .i_mclk       (i_mclk),
        .i_srst       (i_srst),
        .i_set        (done_idle || done_timed),
        .i_read_one   (rd_status && o_readdata[BIT_TRANSMIT_DONE]),
        .i_write_done (wr_status),
        .i_write_zero (wr_status && !i_writedata[BIT_TRANSMIT_DONE]),
        .i_hw_clear   (i_tx_hold_write),
        .o_flag       (transmit_done)
    );

    // ****************************************
    // Interrupts and mirrored control outputs
    // ****************************************
    // Only bits actually returned by the read are cleared, so a late event stays
    wire [IRQ_WIDTH-1:0] irq_events = {transmit_done && !prev_done,
                                       parity_fault && !prev_parity};
    wire [IRQ_WIDTH-1:0] irq_read_clr =
        (rd_done && hit_irqs) ? o_readdata[IRQ_WIDTH-1:0] : 2'h0;
    wire [IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~irq_read_clr) | irq_events;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            prev_parity           <= PARITY_FAULT_RESET;
            prev_done             <= TRANSMIT_DONE_RESET;
            irq_status            <= 2'h0;
            o_irq                 <= 1'b0;
            o_tx_enable_bit       <= 1'b0;
            o_rx_enable_bit       <= 1'b0;
            o_guard_shorten_mode  <= 1'b0;
            o_block_transfer_mode <= 1'b0;
            o_transmit_done_flag  <= TRANSMIT_DONE_RESET;
        end else begin
            prev_parity           <= parity_fault;
            prev_done             <= transmit_done;
            irq_status            <= next_irq_status;
            o_irq                 <= |(next_irq_status & irq_mask);
            o_tx_enable_bit       <= ctrl.tx_enable;
            o_rx_enable_bit       <= ctrl.rx_enable;
            o_guard_shorten_mode  <= ctrl.guard_shorten;
            o_block_transfer_mode <= ctrl.block_mode;
            o_transmit_done_flag  <= transmit_done;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_parity_sets;
        @(posedge i_mclk) disable iff (i_srst)
        i_rx_char_done && i_rx_parity_bad && !parity_fault |=> parity_fault;
    endproperty
    a_parity_sets: assert property (p_parity_sets)
        else $error("parity fault not set after bad character");

    property p_bad_char_no_full;
        @(posedge i_mclk) disable iff (i_srst)
        i_rx_char_done && i_rx_parity_bad && !parity_fault
            |=> o_holding_load && !o_receive_full_set;
    endproperty
    a_bad_char_no_full: assert property (p_bad_char_no_full)
        else $error("bad character handling wrong");

    property p_rx_blocked;
        @(posedge i_mclk) disable iff (i_srst)
        parity_fault |=> !o_holding_load && o_rx_halt;
    endproperty
    a_rx_blocked: assert property (p_rx_blocked)
        else $error("reception continued under parity fault");

    property p_tx_halt_sync;
        @(posedge i_mclk) disable iff (i_srst)
        parity_fault && ctrl.clocked_sync |=> o_tx_halt;
    endproperty
    a_tx_halt_sync: assert property (p_tx_halt_sync)
        else $error("transmit not halted in clocked synchronous mode");

    property p_parity_holds;
        @(posedge i_mclk) disable iff (i_srst)
        parity_fault && !wr_status |=> parity_fault;
    endproperty
    a_parity_holds: assert property (p_parity_holds)
        else $error("parity fault cleared without a write");

    property p_write_one_keeps;
        @(posedge i_mclk) disable iff (i_srst)
        wr_status && i_writedata[BIT_PARITY_FAULT] && parity_fault |=> parity_fault;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("writing one cleared the parity fault");

    property p_rx_enable_drop;
        @(posedge i_mclk) disable iff (i_srst)
        wr_done && hit_ctrl && !i_writedata[1] && parity_fault |=> parity_fault;
    endproperty
    a_rx_enable_drop: assert property (p_rx_enable_drop)
        else $error("receiver disable disturbed parity fault");

    property p_done_reset;
        @(posedge i_mclk)
        i_srst |=> transmit_done && o_transmit_done_flag;
    endproperty
    a_done_reset: assert property (p_done_reset)
        else $error("transmit done not one after reset");

    property p_done_idle;
        @(posedge i_mclk) disable iff (i_srst)
        !ctrl.tx_enable && !i_error_signal_flag |=> transmit_done ##1 o_transmit_done_flag;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("transmit done not set while transmitter idle");

    property p_done_timed;
        @(posedge i_mclk) disable iff (i_srst)
        timer_done && !i_error_signal_flag && i_transmit_empty_flag |=> transmit_done;
    endproperty
    a_done_timed: assert property (p_done_timed)
        else $error("transmit done not set after delay");

    property p_delay_normal;
        @(posedge i_mclk) disable iff (i_srst)
        !ctrl.guard_shorten |-> delay_count == (ctrl.block_mode ? 3'h3 : 3'h5);
    endproperty
    a_delay_normal: assert property (p_delay_normal)
        else $error("wrong delay without guard shortening");

    property p_delay_guard;
        @(posedge i_mclk) disable iff (i_srst)
        i_tx_char_end && ctrl.guard_shorten ##1 (!i_half_etu_tick && !i_tx_char_end)
            ##1 (i_half_etu_tick && !i_tx_char_end) ##1 (!i_half_etu_tick && !i_tx_char_end)[*7]
            ##1 i_half_etu_tick && !i_tx_char_end |=> timer_done;
    endproperty
    a_delay_guard: assert property (p_delay_guard)
        else $error("guard mode delay is not one bit time");

    property p_dma_clears;
        @(posedge i_mclk) disable iff (i_srst)
        i_tx_hold_write && ctrl.tx_enable && !timer_done |=> !transmit_done;
    endproperty
    a_dma_clears: assert property (p_dma_clears)
        else $error("transfer unit write did not clear transmit done");

    property p_mprx_zero;
        @(posedge i_mclk) disable iff (i_srst)
        rd_status |-> !o_readdata[BIT_MULTIPROC_RX];
    endproperty
    a_mprx_zero: assert property (p_mprx_zero)
        else $error("multiprocessor receive bit read as one");

    property p_irq_level;
        @(posedge i_mclk) disable iff (i_srst)
        |(irq_status & irq_mask) && !(rd_done && hit_irqs) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt low with unmasked status set");

    c_parity_event: cover property (@(posedge i_mclk) disable iff (i_srst)
        parity_set ##1 wr_status);
    c_timed_done: cover property (@(posedge i_mclk) disable iff (i_srst)
        done_timed && ctrl.tx_enable);
    c_irq_raised: cover property (@(posedge i_mclk) disable iff (i_srst)
        $rose(o_irq));

endmodule : smart_card_status_flags
`default_nettype wire

/* File: testbench/card_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Card and bit-timing side of the line
// ****************************************
module card_model (
    input  wire logic i_mclk,
    output var  logic o_char_done,
    output var  logic o_parity_bad,
    output var  logic o_char_end,
    output var  logic o_tick,
    output var  logic o_err
);
    initial begin
        o_char_done = 1'b0;
        o_parity_bad = 1'b1;
        o_char_end = 1'b0;
        o_tick = 1'b0;
        o_err = 1'b0;
    end
    // Parity verdict only holds with the character; after it the line flips
    task send_char(input logic bad);
        @(posedge i_mclk);
        o_char_done <= 1'b1;
        o_parity_bad <= bad;
        @(posedge i_mclk);
        o_char_done <= 1'b0;
        o_parity_bad <= ~bad;
    endtask : send_char
    task tx_end;
        @(posedge i_mclk);
        o_char_end <= 1'b1;
        @(posedge i_mclk);
        o_char_end <= 1'b0;
    endtask : tx_end
    task ticks(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            o_tick <= 1'b1;
            @(posedge i_mclk);
            o_tick <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
    endtask : ticks
    task error_low(input logic v);
        @(posedge i_mclk);
        o_err <= v;
    endtask : error_low
endmodule : card_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
    import scstat_pkg::*;
;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        dma = 1'b0;
    logic        tx_empty = 1'b1;
    logic [3:0]  ben = 4'hF;
    logic [3:0]  mir;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        wreq, hload, fset, rxh, txh, done, irq;
    logic        cdone, cbad, cend, ctick, cerr;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    int          nload = 0;
    int          nfull = 0;

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (hload === 1'b1) nload++;
        if (fset === 1'b1) nfull++;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test;
        end
    end

    smart_card_status_flags DUT (
        .i_mclk(mclk), .i_srst(srst), .i_address(adr), .i_read(rd), .i_write(wr),
        .i_writedata(wdat), .i_byteenable(ben), .o_readdata(rdata), .o_waitrequest(wreq),
        .i_rx_char_done(cdone), .i_rx_parity_bad(cbad), .i_tx_char_end(cend),
        .i_half_etu_tick(ctick), .i_error_signal_flag(cerr), .i_transmit_empty_flag(tx_empty),
        .i_tx_hold_write(dma), .o_holding_load(hload), .o_receive_full_set(fset),
        .o_rx_halt(rxh), .o_tx_halt(txh), .o_tx_enable_bit(mir[0]), .o_rx_enable_bit(mir[1]),
        .o_guard_shorten_mode(mir[2]), .o_block_transfer_mode(mir[3]),
        .o_transmit_done_flag(done), .o_irq(irq)
    );
    card_model card (
        .i_mclk(mclk), .o_char_done(cdone), .o_parity_bad(cbad), .o_char_end(cend),
        .o_tick(ctick), .o_err(cerr)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    task stop_test;
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    task wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        adr <= a;
        wdat <= v;
        wr <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        adr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        v = rdata;
        rd <= 1'b0;
    endtask : rd_reg
    task pause(input int n);
        repeat (n) @(posedge mclk);
    endtask : pause

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rd_reg(ADDR_STATUS, d);
        chk("status", 32'h4, d);
        rd_reg(4'h1, d);
        chk("unmapped", 32'h0, d);
    endtask : t_reset
    task t_parity;
        wr_reg(ADDR_CONTROL, 32'h12);
        card.send_char(1'b0);
        card.send_char(1'b1);
        pause(3);
        chk("loads", 32'h2, nload);
        chk("full sets", 32'h1, nfull);
        chk("rx halt", 32'h1, rxh);
        chk("tx halt", 32'h1, txh);
        chk("masked irq", 32'h0, irq);
        chk("mirror rx", 32'h2, mir);
        card.send_char(1'b0);
        pause(3);
        chk("loads held", 32'h2, nload);
        wr_reg(ADDR_CONTROL, 32'h0);
        wr_reg(ADDR_STATUS, 32'h0);
        rd_reg(ADDR_STATUS, d);
        chk("fault kept", 32'h8, d & 32'h8);
        wr_reg(ADDR_IRQ_MASK, 32'h1);
        pause(3);
        chk("irq", 32'h1, irq);
        rd_reg(ADDR_IRQ_STATUS, d);
        chk("irq status", 32'h1, d & 32'h1);
        pause(3);
        chk("irq cleared", 32'h0, irq);
        wr_reg(ADDR_STATUS, 32'h8);
        rd_reg(ADDR_STATUS, d);
        chk("fault after 1", 32'h8, d & 32'h8);
        ben <= 4'h0;
        wr_reg(ADDR_STATUS, 32'h0);
        ben <= 4'hF;
        rd_reg(ADDR_STATUS, d);
        chk("fault lane off", 32'h8, d & 32'h8);
        wr_reg(ADDR_STATUS, 32'h0);
        rd_reg(ADDR_STATUS, d);
        chk("fault cleared", 32'h0, d & 32'h8);
        chk("rx released", 32'h0, rxh);
    endtask : t_parity
    task t_done(input logic [31:0] ctl, input int n);
        wr_reg(ADDR_CONTROL, ctl);
        @(posedge mclk);
        dma <= 1'b1;
        @(posedge mclk);
        dma <= 1'b0;
        pause(3);
        chk("done by dma", 32'h0, done);
        chk("mirror", ctl & 32'hF, mir);
        card.tx_end();
        card.ticks(n - 1);
        pause(4);
        chk("done early", 32'h0, done);
        card.ticks(1);
        pause(4);
        chk("done timed", 32'h1, done);
    endtask : t_done
    task t_clear_done;
        rd_reg(ADDR_STATUS, d);
        wr_reg(ADDR_STATUS, 32'h0);
        pause(3);
        chk("done cleared", 32'h0, done);
    endtask : t_clear_done
    task t_err;
        tx_empty <= 1'b0;
        card.tx_end();
        card.ticks(2);
        pause(4);
        chk("done not empty", 32'h0, done);
        tx_empty <= 1'b1;
        card.error_low(1'b1);
        card.tx_end();
        card.ticks(2);
        pause(4);
        chk("done with error", 32'h0, done);
        wr_reg(ADDR_CONTROL, 32'h0);
        pause(3);
        chk("done tx off err", 32'h0, done);
        card.error_low(1'b0);
        pause(4);
        chk("done tx off", 32'h1, done);
    endtask : t_err

    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_reset;
        t_parity;
        t_done(32'h01, 5);
        t_done(32'h09, 3);
        t_done(32'h05, 2);
        t_done(32'h0D, 2);
        t_clear_done;
        t_err;
        stop_test;
    end
endmodule : tb
`default_nettype wire
